// >>> inc/port_consts.svh
`ifndef PORT_CONSTS_SVH
`define PORT_CONSTS_SVH
// Function
// - single-bit set or clear changes one pin's bit, never the others
// - latch, direction and pin-sample decode at three consecutive descending addresses
// - pin-sample address is read-only; latch and direction are read/write
// - all eight pins behave identically as general digital I/O
// - direction bit one drives the pin, zero makes it an input
// - input pin with latch bit one enables its pull-up
// - pull-up off when latch bit is zero or pin is an output
// - latch address reads stored latch; pin-sample address reads pin levels
// - reset tri-states every pin at once, with or without a clock
// - external-memory enable overrides the first port's direction register
// - external-memory mode carries multiplexed low address and data on first port
// - pull-ups enabled while the first port is the external bus
// - every pin input passes synchronisation flops before internal use
// - transmitter enabled forces the transmit pin to an output
// - receiver enabled forces the receive pin to an input
// - forced receive input gets pull-up when its latch bit is one
// - serial port pins two and three feed external interrupts zero and one

// ==========================================
// i/o addresses
`define A_LATCH_ADDR 6'h1b
`define A_DIR_ADDR 6'h1a
`define A_PINS_ADDR 6'h19
`define D_LATCH_ADDR 6'h12
`define D_DIR_ADDR 6'h11
`define D_PINS_ADDR 6'h10

// ==========================================
// reset values
`define LATCH_RESET 8'h00
`define DIR_RESET 8'h00
`define UNMAPPED_READ 8'h00

// ==========================================
// second port bit positions
`define D_RX_BIT 3'h0
`define D_TX_BIT 3'h1
`define D_IRQ0_BIT 3'h2
`define D_IRQ1_BIT 3'h3

// ==========================================
// synchroniser depth
`define SYNC_STAGES_DEFAULT 2
`endif

// >>> inc/port_pkg.sv
package port_pkg;

  // one i/o access from the core, all fields sampled on the same edge
  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic bit_set;
    logic bit_clr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } io_req_t;

  // pad drive for one 8-pin port
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] o;
    logic [7:0] pu;
  } pin_ctl_t;

  // complete state of the port block
  typedef struct packed {
    logic [7:0] a_latch;
    logic [7:0] a_dir;
    logic [7:0] d_latch;
    logic [7:0] d_dir;
    logic [7:0] rdata;
    pin_ctl_t a_pins;
    pin_ctl_t d_pins;
  } port_state_t;

endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 8,
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // raw and synchronised levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // refused at elaboration: a single stage would leave the chain slice empty
  if (STAGES < 2) begin : g_bad_stages
    $error("pin_sync needs at least two stages");
  end

  // ==========================================
  // per-pin chain; the first stage feeds only the next one
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      logic [STAGES-1:0] chain_r;
      logic [STAGES-1:0] chain_nxt;
      always_comb begin
        chain_nxt = {chain_r[STAGES-2:0], d[i]};
      end
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          chain_r <= '0;
        end else begin
          chain_r <= chain_nxt;
        end
      end
      assign q[i] = chain_r[STAGES-1];
    end
  endgenerate

endmodule
`default_nettype wire

// >>> rtl/bidir_port_with_overrides.sv
`timescale 1ns/100ps
`default_nettype none
`include "port_consts.svh"
module bidir_port_with_overrides
  import port_pkg::*;
#(
  parameter int SYNC_STAGES = `SYNC_STAGES_DEFAULT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,

  // core i/o access
  input wire io_req_t io_req,
  output logic [7:0] io_rdata,

  // first port pads
  input wire logic [7:0] first_port_pin_in,
  output logic [7:0] first_port_pin_out,
  output logic [7:0] first_port_pin_oe,
  output logic [7:0] first_port_pin_pullup,

  // second (serial) port pads
  input wire logic [7:0] fourth_port_pin_in,
  output logic [7:0] fourth_port_pin_out,
  output logic [7:0] fourth_port_pin_oe,
  output logic [7:0] fourth_port_pin_pullup,

  // external memory interface
  input wire logic external_memory_enable,
  input wire logic xmem_drive,
  input wire logic [7:0] xmem_addr_data_out,
  output logic [7:0] xmem_addr_data_in,

  // serial port
  input wire logic uart_tx_enable,
  input wire logic uart_rx_enable,
  input wire logic uart_txd,
  output logic uart_rxd,

  // external interrupt sources
  output logic ext_irq_zero,
  output logic ext_irq_one
);

  // ==========================================
  // elaboration checks
  if (SYNC_STAGES < 2) begin : g_bad_stages
    $error("SYNC_STAGES must be at least two");
  end

  // ==========================================
  // state
  port_state_t st_r;
  port_state_t st_nxt;

  logic [7:0] a_sync;
  logic [7:0] d_sync;

  // ==========================================
  // input synchronisers
  pin_sync #(
    .W(8),
    .STAGES(SYNC_STAGES)
  ) u_sync_a (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d(first_port_pin_in),
    .q(a_sync)
  );

  pin_sync #(
    .W(8),
    .STAGES(SYNC_STAGES)
  ) u_sync_d (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d(fourth_port_pin_in),
    .q(d_sync)
  );

  // ==========================================
  // helpers

  // one bit of a register changed, the other seven kept
  function automatic logic [7:0] bit_update(
    input logic [7:0] cur,
    input logic [2:0] sel,
    input logic set_bit
  );
    logic [7:0] res;
    res = cur;
    res[sel] = set_bit;
    return res;
  endfunction

  // plain digital i/o; identical for all eight pins
  function automatic pin_ctl_t gp_ctl(
    input logic [7:0] latch,
    input logic [7:0] dir
  );
    pin_ctl_t c;
    c.oe = dir;
    c.o = latch;
    c.pu = latch & ~dir;
    return c;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    st_nxt = st_r;

    // full-byte writes; the pin-sample addresses take no write
    if (io_req.wr) begin
      case (io_req.addr)
        `A_LATCH_ADDR: begin
          st_nxt.a_latch = io_req.wdata;
        end
        `A_DIR_ADDR: begin
          st_nxt.a_dir = io_req.wdata;
        end
        `D_LATCH_ADDR: begin
          st_nxt.d_latch = io_req.wdata;
        end
        `D_DIR_ADDR: begin
          st_nxt.d_dir = io_req.wdata;
        end
        default: begin
          st_nxt.a_latch = st_r.a_latch;
        end
      endcase
    end else if (io_req.bit_set || io_req.bit_clr) begin
      // set wins if both strobes arrive together
      case (io_req.addr)
        `A_LATCH_ADDR: begin
          st_nxt.a_latch = bit_update(st_r.a_latch, io_req.bit_sel, io_req.bit_set);
        end
        `A_DIR_ADDR: begin
          st_nxt.a_dir = bit_update(st_r.a_dir, io_req.bit_sel, io_req.bit_set);
        end
        `D_LATCH_ADDR: begin
          st_nxt.d_latch = bit_update(st_r.d_latch, io_req.bit_sel, io_req.bit_set);
        end
        `D_DIR_ADDR: begin
          st_nxt.d_dir = bit_update(st_r.d_dir, io_req.bit_sel, io_req.bit_set);
        end
        default: begin
          st_nxt.d_dir = st_r.d_dir;
        end
      endcase
    end

    // read data is held until the next read
    if (io_req.rd) begin
      case (io_req.addr)
        `A_LATCH_ADDR: begin
          st_nxt.rdata = st_r.a_latch;
        end
        `A_DIR_ADDR: begin
          st_nxt.rdata = st_r.a_dir;
        end
        `A_PINS_ADDR: begin
          st_nxt.rdata = a_sync;
        end
        `D_LATCH_ADDR: begin
          st_nxt.rdata = st_r.d_latch;
        end
        `D_DIR_ADDR: begin
          st_nxt.rdata = st_r.d_dir;
        end
        `D_PINS_ADDR: begin
          st_nxt.rdata = d_sync;
        end
        default: begin
          st_nxt.rdata = `UNMAPPED_READ;
        end
      endcase
    end

    // first port pad drive, from the updated registers so the pad
    // changes on the same edge as the register
    st_nxt.a_pins = gp_ctl(st_nxt.a_latch, st_nxt.a_dir);
    if (external_memory_enable) begin
      // bus owns the port; direction register is ignored but kept
      st_nxt.a_pins.oe = {8{xmem_drive}};
      st_nxt.a_pins.o = xmem_addr_data_out;
      st_nxt.a_pins.pu = 8'hff;
    end

    // second port pad drive with serial overrides
    st_nxt.d_pins = gp_ctl(st_nxt.d_latch, st_nxt.d_dir);
    if (uart_tx_enable) begin
      st_nxt.d_pins.oe[`D_TX_BIT] = 1'b1;
      st_nxt.d_pins.o[`D_TX_BIT] = uart_txd;
      st_nxt.d_pins.pu[`D_TX_BIT] = 1'b0;
    end
    if (uart_rx_enable) begin
      st_nxt.d_pins.oe[`D_RX_BIT] = 1'b0;
      st_nxt.d_pins.pu[`D_RX_BIT] = st_nxt.d_latch[`D_RX_BIT];
    end
  end

  // ==========================================
  // registers; async reset clears every enable so pads float at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r.a_latch <= `LATCH_RESET;
      st_r.a_dir <= `DIR_RESET;
      st_r.d_latch <= `LATCH_RESET;
      st_r.d_dir <= `DIR_RESET;
      st_r.rdata <= `UNMAPPED_READ;
      st_r.a_pins <= '0;
      st_r.d_pins <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // outputs
  assign io_rdata = st_r.rdata;
  assign first_port_pin_out = st_r.a_pins.o;
  assign first_port_pin_oe = st_r.a_pins.oe;
  assign first_port_pin_pullup = st_r.a_pins.pu;
  assign fourth_port_pin_out = st_r.d_pins.o;
  assign fourth_port_pin_oe = st_r.d_pins.oe;
  assign fourth_port_pin_pullup = st_r.d_pins.pu;

  // internal consumers see synchronised levels only
  assign xmem_addr_data_in = a_sync;
  assign uart_rxd = d_sync[`D_RX_BIT];
  assign ext_irq_zero = d_sync[`D_IRQ0_BIT];
  assign ext_irq_one = d_sync[`D_IRQ1_BIT];

endmodule
`default_nettype wire

// >>> bench/board_model.sv
`timescale 1ns/100ps
`default_nettype none
module board_model (
  // clock
  input wire logic clk,
  // device pad drive
  input wire logic [7:0] oe,
  input wire logic [7:0] o,
  input wire logic [7:0] pu,
  // board drive
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  // resolved level
  output logic [7:0] pin
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge clk) last_r <= pin;
  // a floating pin without pull-up flips each cycle, so nothing may rely on it
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin[i] = oe[i] ? o[i] : ext_en[i] ? ext[i] : pu[i] | ~last_r[i];
    end
  end
endmodule
`default_nettype wire

// >>> bench/port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module port_checker
  import port_pkg::*;
#(parameter int SYNC_STAGES = 2) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // core side
  input wire io_req_t io_req,
  input wire logic [7:0] io_rdata,
  // pads
  input wire logic [7:0] first_port_pin_in,
  input wire logic [7:0] first_port_pin_out,
  input wire logic [7:0] first_port_pin_oe,
  input wire logic [7:0] first_port_pin_pullup,
  input wire logic [7:0] fourth_port_pin_in,
  input wire logic [7:0] fourth_port_pin_out,
  input wire logic [7:0] fourth_port_pin_oe,
  input wire logic [7:0] fourth_port_pin_pullup,
  // overrides and external interrupt lines
  input wire logic external_memory_enable,
  input wire logic xmem_drive,
  input wire logic [7:0] xmem_addr_data_out,
  input wire logic uart_tx_enable,
  input wire logic uart_rx_enable,
  input wire logic uart_txd,
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========
  // edges since release; $past would otherwise see pre-reset pins
  logic [3:0] up_r;
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst) up_r <= 4'h0;
    else if (up_r != 4'hf) up_r <= up_r + 4'h1;
  wire logic settled = up_r > SYNC_STAGES;
  sequence s_pin_rd;
    settled && io_req.rd && io_req.addr == 6'h19;
  endsequence
  // ==========
  // assertions
  a_pin_read: assert property (
    s_pin_rd |=> io_rdata == $past(first_port_pin_in, SYNC_STAGES + 1)) else $error("pin read");
  a_irq_sync: assert property (
    settled |-> {ext_irq_one, ext_irq_zero} == $past(fourth_port_pin_in[3:2], SYNC_STAGES)) else $error("irq");
  a_gpio_pullup: assert property (
    !$past(external_memory_enable) |-> first_port_pin_pullup == (first_port_pin_out & ~first_port_pin_oe))
    else $error("pullup");
  a_dir_write: assert property (
    io_req.wr && io_req.addr == 6'h1a && !external_memory_enable |=> first_port_pin_oe == $past(io_req.wdata))
    else $error("dir write");
  a_xmem_bus: assert property ($past(external_memory_enable) |-> first_port_pin_oe == {8{$past(xmem_drive)}}
    && first_port_pin_out == $past(xmem_addr_data_out)) else $error("xmem bus");
  a_xmem_pullup: assert property ($past(external_memory_enable) |-> first_port_pin_pullup == 8'hff) else $error("xmem pu");
  a_tx_forced: assert property ($past(uart_tx_enable) |-> fourth_port_pin_oe[1] && !fourth_port_pin_pullup[1]
    && fourth_port_pin_out[1] == $past(uart_txd)) else $error("tx pin");
  a_rx_forced: assert property ($past(uart_rx_enable) |-> !fourth_port_pin_oe[0]
    && fourth_port_pin_pullup[0] == fourth_port_pin_out[0]) else $error("rx pin");
  a_reset_tri: assert property (disable iff (1'b0) !nrst |-> (first_port_pin_oe | fourth_port_pin_oe) == 8'h00)
    else $error("reset drive");
endmodule
bind bidir_port_with_overrides port_checker #(.SYNC_STAGES(SYNC_STAGES)) u_chk (.sys_clk, .nrst, .io_req, .io_rdata,
  .first_port_pin_in, .first_port_pin_out, .first_port_pin_oe, .first_port_pin_pullup, .fourth_port_pin_in,
  .fourth_port_pin_out, .fourth_port_pin_oe, .fourth_port_pin_pullup, .external_memory_enable, .xmem_drive,
  .xmem_addr_data_out, .uart_tx_enable, .uart_rx_enable, .uart_txd, .ext_irq_zero, .ext_irq_one);
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t got %h want %h", $time, a, e); end end
module testbench;
  import port_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b1;
  io_req_t io_req = '0;
  logic emem = 1'b0, xdrive = 1'b0, tx_en = 1'b0, rx_en = 1'b0, txd = 1'b0;
  logic [7:0] a_ext = 8'h00, d_ext = 8'h00, a_en = 8'hff, d_en = 8'hff, xout = 8'h00;
  logic [7:0] rdata, a_in, a_out, a_oe, a_pu, d_in, d_out, d_oe, d_pu, xin;
  logic rxd, irq0, irq1;
  int bad_count = 0;
  int cmp_count = 0;
  bidir_port_with_overrides dut (.sys_clk, .nrst, .io_req, .io_rdata(rdata), .first_port_pin_in(a_in),
    .first_port_pin_out(a_out), .first_port_pin_oe(a_oe), .first_port_pin_pullup(a_pu), .fourth_port_pin_in(d_in),
    .fourth_port_pin_out(d_out), .fourth_port_pin_oe(d_oe), .fourth_port_pin_pullup(d_pu),
    .external_memory_enable(emem), .xmem_drive(xdrive), .xmem_addr_data_out(xout), .xmem_addr_data_in(xin),
    .uart_tx_enable(tx_en), .uart_rx_enable(rx_en), .uart_txd(txd), .uart_rxd(rxd), .ext_irq_zero(irq0),
    .ext_irq_one(irq1));
  board_model board_a (.clk(sys_clk), .oe(a_oe), .o(a_out), .pu(a_pu), .ext(a_ext), .ext_en(a_en), .pin(a_in));
  board_model board_d (.clk(sys_clk), .oe(d_oe), .o(d_out), .pu(d_pu), .ext(d_ext), .ext_en(d_en), .pin(d_in));
  // ==========
  // bus tasks: each starts 1 ns after an edge and returns 1 ns after the next; idle returns 1 ns after the nth
  task automatic op(input io_req_t r);
    io_req = r;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    op(io_req_t'{a, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, d});
  endtask
  task automatic bit_op(input logic [5:0] a, input logic s, input logic [2:0] b);
    op(io_req_t'{a, 1'b0, 1'b0, s, !s, b, 8'h00});
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    op(io_req_t'{a, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h00});
    `CHK(rdata, e)
  endtask
  task automatic idle(input int n);
    io_req = '0;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // ==========
  // scenarios
  task automatic t_regs();
    `CHK(a_oe | a_pu, 8'h00)
    rdchk(6'h1b, 8'h00);
    wr(6'h1b, 8'ha5);
    wr(6'h1a, 8'h3c);
    `CHK(a_oe, 8'h3c)
    `CHK(a_pu, 8'h81)
    wr(6'h19, 8'hff);
    rdchk(6'h1b, 8'ha5);
    rdchk(6'h1a, 8'h3c);
    rdchk(6'h3f, 8'h00);
  endtask
  task automatic t_bits();
    logic [7:0] e;
    e = 8'h00;
    wr(6'h1a, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bit_op(6'h1a, 1'b1, 3'(i));
      e[i] = 1'b1;
      `CHK(a_oe, e)
    end
    wr(6'h1b, 8'hff);
    wr(6'h1a, 8'h00);
    for (int i = 7; i >= 0; i--) begin
      bit_op(6'h1b, 1'b0, 3'(i));
      e[i] = 1'b0;
      `CHK(a_pu, e)
    end
  endtask
  task automatic t_pins();
    a_ext = 8'h5a;
    idle(3);
    rdchk(6'h19, 8'h5a);
    wr(6'h1a, 8'hff);
    wr(6'h1b, 8'h0f);
    idle(3);
    rdchk(6'h19, 8'h0f);
  endtask
  task automatic t_xmem();
    a_ext = 8'h96;
    emem = 1'b1;
    xdrive = 1'b1;
    xout = 8'hc3;
    idle(1);
    `CHK({a_oe, a_out, a_pu}, 24'hffc3ff)
    xdrive = 1'b0;
    idle(4);
    `CHK({a_oe, xin}, 16'h0096)
    emem = 1'b0;
    idle(1);
    `CHK({a_oe, a_pu}, 16'hff00)
  endtask
  task automatic t_uart();
    d_ext = 8'h08;
    d_en = 8'hfd;
    wr(6'h12, 8'h01);
    wr(6'h11, 8'h01);
    tx_en = 1'b1;
    rx_en = 1'b1;
    txd = 1'b1;
    idle(4);
    `CHK({d_oe[1:0], d_out[1], d_pu[0]}, 4'b1011)
    `CHK({irq1, irq0, rxd}, 3'b100)
    rdchk(6'h10, 8'h0a);
    rdchk(6'h11, 8'h01);
    bit_op(6'h12, 1'b0, 3'h0);
    `CHK(d_pu[0], 1'b0)
    tx_en = 1'b0;
    rx_en = 1'b0;
    idle(1);
    `CHK(d_oe[1:0], 2'b01)
  endtask
  task automatic t_async();
    #3 nrst = 1'b0;
    #1 `CHK(a_oe | d_oe, 8'h00)
    repeat (2) @(posedge sys_clk);
    #1 nrst = 1'b1;
    rdchk(6'h1a, 8'h00);
  endtask
  // ==========
  // run control
  task automatic complete_run();
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  initial begin
    // a real falling edge, so the asynchronous reset acts before the first clock
    #1 nrst = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 nrst = 1'b1;
    t_regs();
    t_bits();
    t_pins();
    t_xmem();
    t_uart();
    t_async();
    complete_run();
  end
endmodule
`default_nettype wire
